// ### verilog/term_regs_pkg.sv
// constants, field positions and types of the upper terminal register bank
package term_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_CFG5 = 6'h09;
  localparam logic [IDX_W-1:0] IDX_STACK = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_FRAME = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_MSG = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_FCMD = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_STAT = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_BITW = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h10;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h11;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] STAT_KEEP = 16'h071f;
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int FRAME_LSB_US = 100;
  localparam int MSG_LSB_US = 1;
  localparam int CFG_CLK_SEL = 15;
  localparam int CFG_SINGLE = 14;
  localparam int CFG_INH_A = 13;
  localparam int CFG_INH_B = 12;
  localparam int CFG_XZC = 11;
  localparam int CFG_TO_HI = 10;
  localparam int CFG_TO_LO = 9;
  localparam int CFG_GAP = 8;
  localparam int CFG_BCST_DIS = 7;
  localparam int CFG_LATCH = 6;
  localparam int CFG_ADDR_HI = 5;
  localparam int CFG_ADDR_LO = 1;
  localparam int CFG_PAR = 0;
  localparam int BSW_EOM = 15;
  localparam int BSW_SOM = 14;
  localparam int BSW_CHAN = 13;
  localparam int BSW_ERR = 12;
  localparam int BSW_SSET = 11;
  localparam int BSW_FMT = 10;
  localparam int BSW_NORSP = 9;
  localparam int BSW_LOOP = 8;
  localparam int BSW_MSSET = 7;
  localparam int BSW_RTY_HI = 6;
  localparam int BSW_RTY_LO = 5;
  localparam int BSW_GOOD = 4;
  localparam int BSW_ADDR = 3;
  localparam int BSW_WC = 2;
  localparam int BSW_SYNC = 1;
  localparam int BSW_INV = 0;
  localparam int IRQ_W = 4;
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_MSG = 1;
  localparam int IRQ_CMD = 2;
  localparam int IRQ_BSW_ERR = 3;
  typedef enum logic [1:0] {
    MODE_BC = 2'b00,
    MODE_RT = 2'b01,
    MODE_MT = 2'b10
  } eng_mode_t;
endpackage

// ### verilog/term_tick_if.sv
// tick strobes passed from the time base to the register bank
`timescale 1ns/10ps
`default_nettype none
interface term_tick_if;
  logic us_tick;
  logic frame_tick;
  modport gen (output us_tick, output frame_tick);
  modport use_side (input us_tick, input frame_tick);
endinterface
`default_nettype wire

// ### verilog/term_tick_gen.sv
// time base: 1 us strobe and 100 us strobe from pclk
`timescale 1ns/10ps
`default_nettype none
module term_tick_gen
  #(
  parameter int US_DIV = term_regs_pkg::US_CYCLES,
  parameter int FRAME_DIV = term_regs_pkg::FRAME_LSB_US
  )
  (
  input wire logic pclk,
  input wire logic presetn,
  term_tick_if.gen tk
  );
  import term_regs_pkg::*;

  if (US_DIV < 2 || US_DIV > 65535 || FRAME_DIV < 1 || FRAME_DIV > 255)
  begin : g_bad
    $error("term_tick_gen: divider out of range");
  end

  typedef struct packed {
    logic [15:0] us_cnt;
    logic [7:0] fr_cnt;
    logic us_tick;
    logic frame_tick;
  } tick_state_t;

  tick_state_t t_q;
  tick_state_t t_d;

  always_comb
  begin
    t_d = t_q;
    t_d.us_tick = 1'b0;
    t_d.frame_tick = 1'b0;
    if (t_q.us_cnt == 16'(US_DIV - 1))
    begin
      t_d.us_cnt = 16'h0000;
      t_d.us_tick = 1'b1;
      if (t_q.fr_cnt == 8'(FRAME_DIV - 1))
      begin
        t_d.fr_cnt = 8'h00;
        t_d.frame_tick = 1'b1;
      end
      else
      begin
        t_d.fr_cnt = t_q.fr_cnt + 8'h01;
      end
    end
    else
    begin
      t_d.us_cnt = t_q.us_cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t_q <= '0;
    end
    else
    begin
      t_q <= t_d;
    end
  end

  assign tk.us_tick = t_q.us_tick;
  assign tk.frame_tick = t_q.frame_tick;
endmodule
`default_nettype wire

// ### verilog/term_upper_regs.sv
// upper terminal register bank with APB slave, timers and block status word
`timescale 1ns/10ps
`default_nettype none
module term_upper_regs
  #(
  parameter logic [7:0] TO_US0 = 8'h14,
  parameter logic [7:0] TO_US1 = 8'h18,
  parameter logic [7:0] TO_US2 = 8'h32,
  parameter logic [7:0] TO_US3 = 8'h82
  )
  (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [term_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire term_regs_pkg::eng_mode_t eng_mode,
  input wire logic frame_start,
  input wire logic msg_start,
  input wire logic [15:0] msg_budget,
  input wire logic last_cmd_valid,
  input wire logic [15:0] last_cmd,
  input wire logic [15:0] rt_status_in,
  input wire logic [15:0] bit_word_in,
  input wire logic bsw_load,
  input wire logic message_end_flag,
  input wire logic message_start_flag,
  input wire logic channel_used,
  input wire logic status_set,
  input wire logic masked_status_set,
  input wire logic format_error,
  input wire logic no_response,
  input wire logic loop_test_fail,
  input wire logic [1:0] retry_count,
  input wire logic good_block,
  input wire logic wrong_status_addr,
  input wire logic word_count_error,
  input wire logic sync_type_error,
  input wire logic invalid_word,
  output logic [15:0] block_status_word,
  output logic block_status_valid,
  output logic clk_12mhz_sel,
  output logic single_ended,
  output logic tx_inhibit_a,
  output logic tx_inhibit_b,
  output logic expanded_crossing,
  output logic gap_check,
  output logic broadcast_disable,
  output logic terminal_address_latch_control,
  output logic [4:0] terminal_address,
  output logic address_parity_error,
  output logic [7:0] response_timeout_us,
  output logic [15:0] data_stack_pointer,
  output logic [15:0] frame_time_left,
  output logic [15:0] message_time_left
  );
  import term_regs_pkg::*;

  typedef struct packed {
    logic [15:0] cfg5;
    logic [15:0] stack;
    logic [15:0] frame_left;
    logic [15:0] msg_left;
    logic [15:0] fcmd;
    logic [15:0] bsw;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [7:0] to_us;
    logic [31:0] prdata;
    logic irq;
    logic bsw_valid;
    logic par_err;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [IRQ_W-1:0] ev;
  logic acc;
  logic wr;

  term_tick_if tk();

  term_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );

  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[ADDR_W-1:2];
  endfunction

  function automatic logic idx_ok(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] i;
    i = idx_of(a);
    idx_ok = (a[1:0] == 2'b00) && (i >= IDX_CFG5) && (i <= IDX_IRQ_MASK);
  endfunction

  function automatic logic [7:0] to_lookup(input logic [1:0] sel);
    unique case (sel)
      2'b00: to_lookup = TO_US0;
      2'b01: to_lookup = TO_US1;
      2'b10: to_lookup = TO_US2;
      2'b11: to_lookup = TO_US3;
    endcase
  endfunction

  // one wait state: pready rises the cycle after the first access cycle
  assign acc = psel && penable;
  assign wr = acc && s_q.pready && pwrite && !s_q.pslverr;

  always_comb
  begin
    s_d = s_q;
    ev = '0;
    s_d.pready = 1'b0;
    s_d.bsw_valid = 1'b0;
    if (acc && !s_q.pready)
    begin
      s_d.pready = 1'b1;
      s_d.pslverr = !idx_ok(paddr);
      s_d.prdata = 32'h0000_0000;
      if (!pwrite && idx_ok(paddr))
      begin
        unique case (idx_of(paddr))
          IDX_CFG5: s_d.prdata[15:0] = s_q.cfg5;
          IDX_STACK: s_d.prdata[15:0] = s_q.stack;
          IDX_FRAME: s_d.prdata[15:0] = s_q.frame_left;
          IDX_MSG: s_d.prdata[15:0] = s_q.msg_left;
          IDX_FCMD: s_d.prdata[15:0] = s_q.fcmd;
          IDX_STAT: s_d.prdata[15:0] = rt_status_in & STAT_KEEP;
          IDX_BITW: s_d.prdata[15:0] = bit_word_in;
          IDX_IRQ_STAT: s_d.prdata[IRQ_W-1:0] = s_q.irq_stat;
          IDX_IRQ_MASK: s_d.prdata[IRQ_W-1:0] = s_q.irq_mask;
          default: s_d.prdata = 32'h0000_0000;
        endcase
      end
    end
    // frame timer only runs down; it stops at zero and waits for a reload
    if (tk.frame_tick && s_q.frame_left != 16'h0000)
    begin
      s_d.frame_left = s_q.frame_left - 16'h0001;
      if (s_q.frame_left == 16'h0001)
      begin
        ev[IRQ_FRAME] = 1'b1;
      end
    end
    if (frame_start && eng_mode == MODE_BC)
    begin
      s_d.frame_left = s_q.fcmd;
    end
    if (tk.us_tick && s_q.msg_left != 16'h0000)
    begin
      s_d.msg_left = s_q.msg_left - 16'h0001;
      if (s_q.msg_left == 16'h0001)
      begin
        ev[IRQ_MSG] = 1'b1;
      end
    end
    if (msg_start)
    begin
      s_d.msg_left = msg_budget;
    end
    if (wr)
    begin
      unique case (idx_of(paddr))
        IDX_CFG5: s_d.cfg5 = pwdata[15:0];
        IDX_STACK: s_d.stack = pwdata[15:0];
        IDX_FRAME: s_d.frame_left = pwdata[15:0];
        IDX_FCMD: s_d.fcmd = pwdata[15:0];
        IDX_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~pwdata[IRQ_W-1:0];
        IDX_IRQ_MASK: s_d.irq_mask = pwdata[IRQ_W-1:0];
        default: s_d.irq_mask = s_d.irq_mask;
      endcase
    end
    // the engine's capture beats a host write landing in the same cycle
    if (last_cmd_valid && eng_mode == MODE_RT)
    begin
      s_d.fcmd = last_cmd;
      ev[IRQ_CMD] = 1'b1;
    end
    if (bsw_load)
    begin
      s_d.bsw = RST_WORD;
      s_d.bsw[BSW_EOM] = message_end_flag;
      s_d.bsw[BSW_SOM] = message_start_flag;
      s_d.bsw[BSW_CHAN] = channel_used;
      s_d.bsw[BSW_SSET] = status_set;
      s_d.bsw[BSW_MSSET] = masked_status_set;
      s_d.bsw[BSW_FMT] = format_error;
      s_d.bsw[BSW_NORSP] = no_response;
      s_d.bsw[BSW_LOOP] = loop_test_fail;
      s_d.bsw[BSW_ADDR] = wrong_status_addr;
      s_d.bsw[BSW_WC] = word_count_error;
      s_d.bsw[BSW_SYNC] = sync_type_error;
      s_d.bsw[BSW_INV] = invalid_word;
      s_d.bsw[BSW_RTY_HI:BSW_RTY_LO] = retry_count;
      s_d.bsw[BSW_GOOD] = good_block;
      s_d.bsw[BSW_ERR] = format_error | no_response | loop_test_fail |
        wrong_status_addr | word_count_error | sync_type_error |
        invalid_word;
      s_d.bsw_valid = 1'b1;
      ev[IRQ_BSW_ERR] = s_d.bsw[BSW_ERR];
    end
    // set after clear so a same-cycle event survives the write of one
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    s_d.to_us = to_lookup(s_d.cfg5[CFG_TO_HI:CFG_TO_LO]);
    s_d.par_err = ~^s_d.cfg5[CFG_ADDR_HI:CFG_PAR];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irq = s_q.irq;
  assign block_status_word = s_q.bsw;
  assign block_status_valid = s_q.bsw_valid;
  // the engine derives its bit timing from this select
  assign clk_12mhz_sel = s_q.cfg5[CFG_CLK_SEL];
  assign single_ended = s_q.cfg5[CFG_SINGLE];
  assign tx_inhibit_a = s_q.cfg5[CFG_INH_A];
  assign tx_inhibit_b = s_q.cfg5[CFG_INH_B];
  assign expanded_crossing = s_q.cfg5[CFG_XZC];
  assign gap_check = s_q.cfg5[CFG_GAP];
  assign broadcast_disable = s_q.cfg5[CFG_BCST_DIS];
  assign terminal_address_latch_control = s_q.cfg5[CFG_LATCH];
  assign terminal_address = s_q.cfg5[CFG_ADDR_HI:CFG_ADDR_LO];
  assign address_parity_error = s_q.par_err;
  assign response_timeout_us = s_q.to_us;
  assign data_stack_pointer = s_q.stack;
  assign frame_time_left = s_q.frame_left;
  assign message_time_left = s_q.msg_left;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_first_access;
    psel && penable && !pready;
  endsequence

  property p_apb_wait;
    s_setup ##1 s_first_access |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("pready not raised after first access cycle");

  property p_cfg_write;
    wr && idx_of(paddr) == IDX_CFG5 |=>
      tx_inhibit_a == $past(pwdata[CFG_INH_A]) &&
      tx_inhibit_b == $past(pwdata[CFG_INH_B]) &&
      clk_12mhz_sel == $past(pwdata[CFG_CLK_SEL]) ##1
      response_timeout_us == to_lookup($past(pwdata[CFG_TO_HI:CFG_TO_LO], 2));
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config five write not reflected on outputs");

  property p_parity;
    wr && idx_of(paddr) == IDX_CFG5 |=>
      address_parity_error == ~^$past(pwdata[CFG_ADDR_HI:CFG_PAR]);
  endproperty
  a_parity: assert property (p_parity)
    else $error("address parity error flag wrong");

  property p_frame_tick;
    tk.frame_tick && frame_time_left != 16'h0000 && !wr && !frame_start |=>
      frame_time_left == $past(frame_time_left) - 16'h0001;
  endproperty
  a_frame_tick: assert property (p_frame_tick)
    else $error("frame timer did not step on frame tick");

  property p_frame_hold;
    !tk.frame_tick && !wr && !frame_start |=> $stable(frame_time_left);
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("frame timer moved without a frame tick");

  property p_msg_ro;
    wr && idx_of(paddr) == IDX_MSG && !msg_start && !tk.us_tick |=>
      $stable(message_time_left);
  endproperty
  a_msg_ro: assert property (p_msg_ro)
    else $error("write changed message time left");

  property p_msg_tick;
    tk.us_tick && message_time_left != 16'h0000 && !msg_start |=>
      message_time_left == $past(message_time_left) - 16'h0001;
  endproperty
  a_msg_tick: assert property (p_msg_tick)
    else $error("message timer did not step on us tick");

  property p_last_cmd;
    last_cmd_valid && eng_mode == MODE_RT |=> s_q.fcmd == $past(last_cmd);
  endproperty
  a_last_cmd: assert property (p_last_cmd)
    else $error("last command not captured");

  sequence s_read_at(logic [IDX_W-1:0] i);
    s_first_access and (!pwrite && idx_of(paddr) == i && paddr[1:0] == 2'b00);
  endsequence

  property p_stat_read;
    s_read_at(IDX_STAT) |=>
      prdata == {16'h0000, $past(rt_status_in) & STAT_KEEP};
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status copy read shows masked bits");

  property p_bit_read;
    s_read_at(IDX_BITW) |=> prdata == {16'h0000, $past(bit_word_in)};
  endproperty
  a_bit_read: assert property (p_bit_read)
    else $error("built-in-test word read wrong");

  property p_bsw;
    bsw_load |=> block_status_valid &&
      block_status_word[BSW_RTY_HI:BSW_RTY_LO] == $past(retry_count) &&
      block_status_word[BSW_SSET] == $past(status_set) &&
      block_status_word[BSW_MSSET] == $past(masked_status_set) &&
      block_status_word[BSW_EOM] == $past(message_end_flag) ##1
      !block_status_valid || $past(bsw_load);
  endproperty
  a_bsw: assert property (p_bsw)
    else $error("block status word fields wrong");

  property p_bsw_err;
    bsw_load && (format_error || invalid_word) |=>
      block_status_word[BSW_ERR] && s_q.irq_stat[IRQ_BSW_ERR];
  endproperty
  a_bsw_err: assert property (p_bsw_err)
    else $error("error flag or event missing in block status");

  property p_irq;
    ##1 irq == |(s_q.irq_stat & s_q.irq_mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output disagrees with status and mask");
endmodule
`default_nettype wire

// ### bench/engine_model.sv
// engine side model: mode, status levels and strobes toward the bank
`timescale 1ns/10ps
`default_nettype none
module engine_model
  (
  input wire logic pclk,
  output var term_regs_pkg::eng_mode_t eng_mode,
  output logic [15:0] rt_status_in,
  output logic [15:0] bit_word_in,
  output logic [15:0] data,
  output logic [3:0] st
  );
  import term_regs_pkg::*;
  initial
  begin
    eng_mode = MODE_BC;
    rt_status_in = 16'h0000;
    bit_word_in = 16'h0000;
    data = 16'h0000;
    st = 4'h0;
  end
  task set_lv(input eng_mode_t m, input logic [15:0] s,
    input logic [15:0] b);
    @(posedge pclk);
    eng_mode <= m;
    rt_status_in <= s;
    bit_word_in <= b;
  endtask
  // strobe: 0 frame start, 1 message start, 2 last command, 3 block status
  task strobe(input int k, input logic [15:0] v);
    @(posedge pclk);
    data <= v;
    st[k[1:0]] <= 1'b1;
    @(posedge pclk);
    st <= 4'h0;
    data <= ~v; // value only good with its strobe, so never left stale
  endtask
endmodule
`default_nettype wire

// ### bench/tb_bus_terminal_upper_register_bank.sv
// self-checking bench for the upper terminal register bank
`timescale 1ns/10ps
`default_nettype none
module tb_bus_terminal_upper_register_bank;
  import term_regs_pkg::*;
  typedef struct packed {logic [31:0] v; logic e; logic r;} note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic bsv, ape;
  logic [7:0] paddr, rto;
  logic [4:0] ta;
  logic [31:0] pwdata, prdata, rnd;
  logic [15:0] bsw, dsp, ftl, mtl, cfg, v, rts, bw;
  wire logic [15:0] data;
  wire logic [3:0] st;
  wire logic [7:0] co;
  eng_mode_t mode;
  logic [7:0] tov [4] = '{8'h14, 8'h18, 8'h32, 8'h82};
  note_t rq[$];
  logic [15:0] bq[$];
  int bad_count, checks_done, seed;
  engine_model engine_model_i
    (
    .pclk(pclk), .eng_mode(mode), .rt_status_in(rts), .bit_word_in(bw),
    .data(data), .st(st)
    );
  term_upper_regs term_upper_regs_i
    (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .eng_mode(mode),
    .frame_start(st[0]), .msg_start(st[1]), .msg_budget(data),
    .last_cmd_valid(st[2]), .last_cmd(data), .rt_status_in(rts),
    .bit_word_in(bw), .bsw_load(st[3]), .message_end_flag(data[15]),
    .message_start_flag(data[14]), .channel_used(data[13]),
    .status_set(data[11]), .format_error(data[10]),
    .no_response(data[9]), .loop_test_fail(data[8]),
    .masked_status_set(data[7]), .retry_count(data[6:5]),
    .good_block(data[4]), .wrong_status_addr(data[3]),
    .word_count_error(data[2]), .sync_type_error(data[1]),
    .invalid_word(data[0]), .block_status_word(bsw),
    .block_status_valid(bsv), .clk_12mhz_sel(co[7]),
    .single_ended(co[6]), .tx_inhibit_a(co[5]), .tx_inhibit_b(co[4]),
    .expanded_crossing(co[3]), .gap_check(co[2]),
    .broadcast_disable(co[1]), .terminal_address_latch_control(co[0]),
    .terminal_address(ta), .address_parity_error(ape),
    .response_timeout_us(rto), .data_stack_pointer(dsp),
    .frame_time_left(ftl), .message_time_left(mtl)
    );
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [7:0] ba(input logic [5:0] i);
    return {i, 2'b00};
  endfunction
  task automatic chk(input string s, input logic [31:0] x,
    input logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  task final_report;
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one apb transfer; the expected answer goes on the queue first
  task apb(input logic w, input logic [7:0] a, input logic [15:0] d,
    input logic [15:0] x, input logic e);
    rnd = $random(seed);
    rq.push_back(note_t'{{16'h0, x}, e, !w});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {rnd[31:16], d};
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is the watchdog's case
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles that a timer holds one value: that one span must equal the expected count x
  task gap(input logic f, input logic [15:0] a, input int x);
    int c;
    c = 0;
    while ((f ? ftl : mtl) !== a && c < 30000)
    begin
      @(posedge pclk);
      c++;
    end
    c = 0;
    while ((f ? ftl : mtl) === a && c < 30000)
    begin
      @(posedge pclk);
      c++;
    end
    chk("tick_span", 32'(x), 32'(c));
  endtask
  always @(posedge pclk)
  begin
    if (psel && penable && pready)
    begin
      automatic note_t nt = note_t'{32'hx, 1'bx, 1'b1};
      if (rq.size() > 0)
        nt = rq.pop_front();
      if (nt.r)
        chk("prdata", nt.v, prdata);
      chk("pslverr", 32'(nt.e), 32'(pslverr));
    end
    if (bsv)
      chk("block_status_word", 32'(bq.size() ? bq.pop_front() : 'x),
        32'(bsw));
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    final_report;
  end
  initial
  begin
    seed = 49231;
    bad_count = 0;
    checks_done = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 9; i < 18; i++)
      apb(1'b0, ba(6'(i)), 16'h0, 16'h0, 1'b0);
    apb(1'b0, 8'h48, 16'h0, 16'h0, 1'b1);
    apb(1'b1, 8'h25, 16'h0, 16'h0, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      cfg = 16'($random(seed));
      cfg[10:9] = 2'(i);
      apb(1'b1, ba(IDX_CFG5), cfg, 16'h0, 1'b0);
      apb(1'b0, ba(IDX_CFG5), 16'h0, cfg, 1'b0);
      chk("cfg_pins", 32'({cfg[15:11], cfg[8:6]}), 32'(co));
      chk("terminal_address", 32'(cfg[5:1]), 32'(ta));
      chk("parity", 32'(~^cfg[5:0]), 32'(ape));
      chk("timeout", 32'(tov[i]), 32'(rto));
    end
    apb(1'b0, ba(IDX_CFG5) | 8'h02, 16'h0, 16'h0, 1'b1);
    v = 16'($random(seed));
    apb(1'b1, ba(IDX_STACK), v, 16'h0, 1'b0);
    apb(1'b0, ba(IDX_STACK), 16'h0, v, 1'b0);
    chk("data_stack_pointer", 32'(v), 32'(dsp));
    engine_model_i.set_lv(MODE_RT, 16'hffff, v);
    apb(1'b1, ba(IDX_MSG), 16'hffff, 16'h0, 1'b0);
    apb(1'b1, ba(IDX_STAT), 16'hffff, 16'h0, 1'b0);
    apb(1'b1, ba(IDX_BITW), ~v, 16'h0, 1'b0);
    apb(1'b0, ba(IDX_MSG), 16'h0, 16'h0, 1'b0);
    apb(1'b0, ba(IDX_STAT), 16'h0, 16'h071f, 1'b0);
    apb(1'b0, ba(IDX_BITW), 16'h0, v, 1'b0);
    engine_model_i.strobe(2, ~v);
    apb(1'b0, ba(IDX_FCMD), 16'h0, ~v, 1'b0);
    engine_model_i.set_lv(MODE_MT, 16'h0, 16'h0);
    apb(1'b1, ba(IDX_FCMD), v, 16'h0, 1'b0);
    engine_model_i.strobe(2, 16'h1234);
    apb(1'b0, ba(IDX_FCMD), 16'h0, v, 1'b0);
    engine_model_i.set_lv(MODE_BC, 16'h0, 16'h0);
    apb(1'b1, ba(IDX_IRQ_MASK), 16'h0003, 16'h0, 1'b0);
    apb(1'b1, ba(IDX_FRAME), 16'h0002, 16'h0, 1'b0);
    engine_model_i.strobe(1, 16'h0005);
    apb(1'b1, ba(IDX_MSG), 16'h0000, 16'h0, 1'b0);
    gap(1'b0, 16'h0003, 100);
    gap(1'b1, 16'h0001, 10000);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b0, ba(IDX_IRQ_STAT), 16'h0, 16'h0007, 1'b0);
    apb(1'b1, ba(IDX_IRQ_STAT), 16'h0007, 16'h0, 1'b0);
    apb(1'b0, ba(IDX_IRQ_STAT), 16'h0, 16'h0000, 1'b0);
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, ba(IDX_FCMD), 16'h0030, 16'h0, 1'b0);
    engine_model_i.strobe(0, 16'h0);
    @(posedge pclk);
    chk("frame_time_left", 32'h30, 32'(ftl));
    for (int i = 0; i < 9; i++)
    begin
      v = (i == 8) ? 16'h0001 : 16'($random(seed));
      v[12] = |{v[10:8], v[3:0]};
      bq.push_back(v);
      engine_model_i.strobe(3, v);
    end
    apb(1'b1, ba(IDX_IRQ_MASK), 16'h0008, 16'h0, 1'b0);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, ba(IDX_IRQ_STAT), 16'h0008, 16'h0, 1'b0);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, 32'(irq));
    // every noted answer must have shown up, or its compare never ran
    chk("apb_notes_left", 32'h0, 32'(rq.size()));
    chk("bsw_notes_left", 32'h0, 32'(bq.size()));
    final_report;
  end
endmodule
`default_nettype wire
